/* hdl/palette_dac_host_bus_port.sv */
// Purpose: strobe-driven 8-bit host port of a color palette converter core
// Assumes: host strobes, selects and data are asynchronous to sys_clk
// Notes: strobes sampled through two flip-flops, edges acted on in sys_clk
//
// Behaviour
// - write data taken at write strobe rise
// - write selects taken at write strobe fall
// - bus driven only while read strobe low
// - read selects taken at read strobe fall
// - selects decide the access kind
// - eight bit bus, bit zero is lsb
// - width input picks eight or six bits
// - eight bit mode: bit seven is msb
// - six bit mode: color data bit five msb, upper ignored
// - six bit color reads drive bits six, seven zero
// - decode the eight select codes
// - red, green, blue; store on blue, increment
// - phase counter clears on address write only
// - index wraps; overlay ignores upper four bits
`timescale 1ns/1ps
module palette_dac_host_bus_port (
  input wire logic sys_clk,
  input wire logic rst_n,
  input palette_port_pkg::host_ctrl_t host_ctrl,
  input wire logic [7:0] host_bus_bits_i,
  output logic [7:0] host_bus_bits_o,
  output logic [7:0] host_bus_bits_oe,
  input wire logic [7:0] pixel_index,
  input wire logic [3:0] overlay_select,
  output logic [23:0] pixel_color
);
  import palette_port_pkg::*;

  // ------------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------------
  // all host pins are asynchronous, so every one passes two flops
  host_ctrl_t ctrl_meta_q, ctrl_sync_q, ctrl_prev_q;
  logic [7:0] data_meta_q, data_sync_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_meta_q <= '{wr_n: 1'b1, rd_n: 1'b1, register_select: 3'h0, width_8bit: 1'b0};
      ctrl_sync_q <= '{wr_n: 1'b1, rd_n: 1'b1, register_select: 3'h0, width_8bit: 1'b0};
      ctrl_prev_q <= '{wr_n: 1'b1, rd_n: 1'b1, register_select: 3'h0, width_8bit: 1'b0};
      data_meta_q <= 8'h00;
      data_sync_q <= 8'h00;
    end else begin
      ctrl_meta_q <= host_ctrl;
      ctrl_sync_q <= ctrl_meta_q;
      ctrl_prev_q <= ctrl_sync_q;
      data_meta_q <= host_bus_bits_i;
      data_sync_q <= data_meta_q;
    end
  end

  logic wr_fall, wr_rise, rd_fall, rd_rise;
  assign wr_fall = ctrl_prev_q.wr_n & ~ctrl_sync_q.wr_n;
  assign wr_rise = ~ctrl_prev_q.wr_n & ctrl_sync_q.wr_n;
  assign rd_fall = ctrl_prev_q.rd_n & ~ctrl_sync_q.rd_n;
  assign rd_rise = ~ctrl_prev_q.rd_n & ctrl_sync_q.rd_n;

  // ------------------------------------------------------------------
  // select capture
  // ------------------------------------------------------------------
  logic [2:0] wr_sel_q, rd_sel_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_sel_q <= 3'h0;
    end else if (wr_fall) begin
      wr_sel_q <= ctrl_sync_q.register_select;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_sel_q <= 3'h0;
    end else if (rd_fall) begin
      rd_sel_q <= ctrl_sync_q.register_select;
    end
  end

  function automatic logic is_color(input logic [2:0] sel);
    is_color = (sel == SEL_PALETTE) || (sel == SEL_OVERLAY);
  endfunction

  function automatic logic [7:0] chan_in(input logic [7:0] d, input logic w8);
    chan_in = w8 ? d : {2'h0, d[5:0]};
  endfunction

  function automatic logic is_addr(input logic [2:0] sel);
    is_addr = (sel == SEL_ADDR_WR_RAM) || (sel == SEL_ADDR_RD_RAM) ||
              (sel == SEL_ADDR_WR_OVL) || (sel == SEL_ADDR_RD_OVL);
  endfunction

  // ------------------------------------------------------------------
  // address, phase, storage
  // ------------------------------------------------------------------
  logic [7:0] index_q, mask_q;
  logic [1:0] phase_q;
  logic [7:0] red_q, green_q;
  logic [23:0] palette_q [PAL_DEPTH];
  logic [23:0] overlay_q [OVL_DEPTH];
  logic [23:0] rd_word_q;
  logic color_write, color_read_done, addr_write;
  logic [7:0] wr_chan;
  logic [23:0] wr_word;

  assign color_write = wr_rise && is_color(wr_sel_q);
  assign color_read_done = rd_rise && is_color(rd_sel_q);
  assign wr_chan = chan_in(data_sync_q, ctrl_sync_q.width_8bit);
  assign wr_word = {red_q, green_q, wr_chan};
  assign addr_write = wr_rise && is_addr(wr_sel_q);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PHASE_RED;
    end else if (addr_write) begin
      phase_q <= PHASE_RED;
    end else if (color_write || color_read_done) begin
      phase_q <= (phase_q == PHASE_BLUE) ? PHASE_RED : phase_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      index_q <= INDEX_RESET;
    end else if (addr_write) begin
      index_q <= data_sync_q;
    end else if ((color_write || color_read_done) && phase_q == PHASE_BLUE) begin
      index_q <= index_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= MASK_RESET;
    end else if (wr_rise && wr_sel_q == SEL_READ_MASK) begin
      mask_q <= data_sync_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      red_q <= 8'h00;
      green_q <= 8'h00;
    end else if (color_write && phase_q == PHASE_RED) begin
      red_q <= wr_chan;
    end else if (color_write && phase_q == PHASE_GREEN) begin
      green_q <= wr_chan;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PAL_DEPTH; i++) palette_q[i] <= COLOR_RESET;
    end else if (color_write && phase_q == PHASE_BLUE && wr_sel_q == SEL_PALETTE) begin
      palette_q[index_q] <= wr_word;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < OVL_DEPTH; i++) overlay_q[i] <= COLOR_RESET;
    end else if (color_write && phase_q == PHASE_BLUE && wr_sel_q == SEL_OVERLAY) begin
      overlay_q[index_q[3:0]] <= wr_word;
    end
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  logic [7:0] rd_chan, rd_value;

  always_comb begin
    case (phase_q)
      PHASE_RED: rd_chan = rd_word_q[RED_LSB +: CHAN_W];
      PHASE_GREEN: rd_chan = rd_word_q[GRN_LSB +: CHAN_W];
      default: rd_chan = rd_word_q[BLU_LSB +: CHAN_W];
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_word_q <= COLOR_RESET;
    end else if (ctrl_sync_q.register_select == SEL_OVERLAY) begin
      rd_word_q <= overlay_q[index_q[3:0]];
    end else begin
      rd_word_q <= palette_q[index_q];
    end
  end

  always_comb begin
    case (rd_sel_q)
      SEL_ADDR_WR_RAM, SEL_ADDR_RD_RAM, SEL_ADDR_WR_OVL, SEL_ADDR_RD_OVL: rd_value = index_q;
      SEL_READ_MASK: rd_value = mask_q;
      SEL_PALETTE, SEL_OVERLAY:
        rd_value = ctrl_sync_q.width_8bit ? rd_chan : {2'h0, rd_chan[5:0]};
      default: rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_bus_bits_o <= 8'h00;
      host_bus_bits_oe <= 8'h00;
    end else begin
      host_bus_bits_o <= rd_value;
      host_bus_bits_oe <= (!ctrl_sync_q.rd_n && !rd_fall) ? 8'hff : 8'h00;
    end
  end

  // pixel side lookup, overlay wins when selected
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pixel_color <= COLOR_RESET;
    end else if (overlay_select != 4'h0) begin
      pixel_color <= overlay_q[overlay_select];
    end else begin
      pixel_color <= palette_q[pixel_index & mask_q];
    end
  end

endmodule // palette_dac_host_bus_port

/* hdl/palette_port_pkg.sv */
// Purpose: shared constants and carriers for the palette host port
// Assumes: 40 MHz system clock, strobes arrive asynchronously from the host
// Notes: select codes as decoded by the host port
package palette_port_pkg;

  localparam int DATA_W = 8;
  localparam int SEL_W = 3;
  localparam int COLOR_W = 24;
  localparam int IDX_W = 8;
  localparam int OVL_IDX_W = 4;
  localparam int PAL_DEPTH = 256;
  localparam int OVL_DEPTH = 16;
  localparam int CHAN_W = 8;
  localparam int SIX_W = 6;
  localparam int RED_LSB = 16;
  localparam int GRN_LSB = 8;
  localparam int BLU_LSB = 0;

  // ------------------------------------------------------------------
  // select codes
  // ------------------------------------------------------------------
  localparam logic [2:0] SEL_ADDR_WR_RAM = 3'h0;
  localparam logic [2:0] SEL_PALETTE = 3'h1;
  localparam logic [2:0] SEL_READ_MASK = 3'h2;
  localparam logic [2:0] SEL_ADDR_RD_RAM = 3'h3;
  localparam logic [2:0] SEL_ADDR_WR_OVL = 3'h4;
  localparam logic [2:0] SEL_OVERLAY = 3'h5;
  localparam logic [2:0] SEL_RESERVED = 3'h6;
  localparam logic [2:0] SEL_ADDR_RD_OVL = 3'h7;

  // color phase values
  localparam logic [1:0] PHASE_RED = 2'h0;
  localparam logic [1:0] PHASE_GREEN = 2'h1;
  localparam logic [1:0] PHASE_BLUE = 2'h2;

  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [23:0] COLOR_RESET = 24'h000000;

  typedef struct packed {
    logic wr_n;
    logic rd_n;
    logic [2:0] register_select;
    logic width_8bit;
  } host_ctrl_t;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } host_drive_t;

  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_WRITE,
    ACC_READ
  } acc_kind_t;

endpackage

/* sim/palette_port_props.sv */
// Purpose: port checks on the palette host port
// Assumes: strobes held at least six clocks by the host
// Notes: sees only the top module's ports
`timescale 1ns/1ps
module palette_port_props
  import palette_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input palette_port_pkg::host_ctrl_t host_ctrl,
  input wire logic [7:0] host_bus_bits_o,
  input wire logic [7:0] host_bus_bits_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic rdl = !host_ctrl.rd_n;
  wire logic [2:0] sel = host_ctrl.register_select;
  AST_OE_IDLE: assert property (host_ctrl.rd_n [*6] |-> host_bus_bits_oe == 8'h00)
    else $error("bus driven while read strobe high");
  AST_OE_ON: assert property (rdl [*6] |-> host_bus_bits_oe == 8'hff)
    else $error("bus not driven during read");
  AST_OE_WHOLE: assert property (host_bus_bits_oe == 8'h00 || host_bus_bits_oe == 8'hff)
    else $error("partial bus drive");
  AST_SIX_TOP: assert property ((rdl [*6]) ##0 (!host_ctrl.width_8bit &&
    (sel == SEL_PALETTE || sel == SEL_OVERLAY)) |-> host_bus_bits_o[7:6] == 2'h0)
    else $error("upper bits set on six bit color read");
  AST_RESV_ZERO: assert property ((rdl [*6]) ##0 (sel == SEL_RESERVED)
    |-> host_bus_bits_o == 8'h00)
    else $error("reserved read not zero");
  AST_HOLD: assert property (host_bus_bits_oe == 8'hff && $past(host_bus_bits_oe) == 8'hff
    && rdl |-> $stable(host_bus_bits_o))
    else $error("read data moved during strobe");
  AST_OFF_AFTER: assert property ($rose(host_ctrl.rd_n) |-> ##[1:5] host_bus_bits_oe == 8'h00)
    else $error("bus not released after read");
  AST_ON_AFTER: assert property ($fell(host_ctrl.rd_n) |-> ##[2:6] host_bus_bits_oe == 8'hff)
    else $error("read answer late");
  AST_WR_QUIET: assert property (!host_ctrl.wr_n |-> host_bus_bits_oe == 8'h00)
    else $error("bus driven during write");
endmodule // palette_port_props

/* sim/palette_host_model.sv */
// Purpose: host processor driving the strobe bus
// Assumes: strobe low eight clocks, idle six after
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps
module palette_host_model
  import palette_port_pkg::*;
(
  input wire logic sys_clk,
  output palette_port_pkg::host_ctrl_t ctrl,
  output logic [7:0] drv
);
  initial begin
    ctrl = '{1'b1, 1'b1, 3'h0, 1'b1};
    drv = 8'h00;
  end
  task automatic xfer(input logic rd, input logic [2:0] s, input logic [7:0] d,
                      input logic w8);
    @(negedge sys_clk);
    ctrl.register_select = s;
    ctrl.width_8bit = w8;
    drv = rd ? ~drv : d;
    @(negedge sys_clk);
    if (rd) ctrl.rd_n = 1'b0;
    else ctrl.wr_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    ctrl.rd_n = 1'b1;
    ctrl.wr_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    drv = ~drv;
    repeat (3) @(negedge sys_clk);
  endtask
endmodule // palette_host_model

/* sim/palette_dac_host_bus_port_tb.sv */
// Purpose: self-checking bench for the palette host port
// Assumes: host model paces every strobe
// Notes: reads are queued by the driver, compared when the bus drives
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h seen %h", n, e, s); end end
module palette_dac_host_bus_port_tb;
  import palette_port_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  host_ctrl_t ctrl;
  logic [7:0] drv, bus, o, oe, e;
  logic [7:0] pix = 8'h00;
  logic [3:0] ovl = 4'h0;
  logic [23:0] color;
  logic [7:0] exp_q[$];
  logic [7:0] c[3];
  logic seen = 1'b0;
  int n_errors = 0;
  int n_compared = 0;
  // wire level from both drivers
  assign bus = (oe & o) | (~oe & drv);
  palette_dac_host_bus_port dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .host_ctrl(ctrl),
    .host_bus_bits_i(bus), .host_bus_bits_o(o), .host_bus_bits_oe(oe),
    .pixel_index(pix), .overlay_select(ovl), .pixel_color(color));
  palette_host_model hm (.sys_clk(sys_clk), .ctrl(ctrl), .drv(drv));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic wr(input logic [2:0] s, input logic [7:0] d, input logic w8);
    hm.xfer(1'b0, s, d, w8);
  endtask
  task automatic rd(input logic [2:0] s, input logic [7:0] x, input logic w8);
    exp_q.push_back(x);
    hm.xfer(1'b1, s, 8'h00, w8);
  endtask
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(negedge sys_clk) begin
    if (oe === 8'hff && !seen) begin
      e = exp_q.pop_front();
      `CHK("read_data", e, o)
    end
    seen = (oe === 8'hff);
  end
  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(10130));
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    foreach (c[i]) c[i] = 8'($urandom);
    wr(SEL_ADDR_WR_RAM, 8'hff, 1'b1);
    foreach (c[i]) wr(SEL_PALETTE, c[i], 1'b1);
    pix = 8'hff;
    repeat (6) @(negedge sys_clk);
    `CHK("pixel_color", {c[0], c[1], c[2]}, color)
    wr(SEL_ADDR_RD_RAM, 8'hff, 1'b1);
    foreach (c[i]) rd(SEL_PALETTE, c[i], 1'b1);
    rd(SEL_ADDR_WR_RAM, 8'h00, 1'b1);
    // phase survives an address read
    wr(SEL_ADDR_WR_RAM, 8'h07, 1'b0);
    wr(SEL_PALETTE, c[0], 1'b0);
    rd(SEL_ADDR_RD_RAM, 8'h07, 1'b0);
    wr(SEL_PALETTE, c[1], 1'b0);
    wr(SEL_PALETTE, c[2], 1'b0);
    wr(SEL_ADDR_RD_RAM, 8'h07, 1'b0);
    foreach (c[i]) rd(SEL_PALETTE, c[i] & 8'h3f, 1'b0);
    // upper index bits dropped for overlays
    wr(SEL_ADDR_WR_OVL, 8'h13, 1'b1);
    foreach (c[i]) wr(SEL_OVERLAY, c[i], 1'b1);
    ovl = 4'h3;
    repeat (6) @(negedge sys_clk);
    `CHK("overlay_color", {c[0], c[1], c[2]}, color)
    wr(SEL_ADDR_RD_OVL, 8'h23, 1'b1);
    foreach (c[i]) rd(SEL_OVERLAY, c[i], 1'b1);
    rd(SEL_ADDR_RD_OVL, 8'h24, 1'b1);
    wr(SEL_READ_MASK, 8'h5a, 1'b1);
    rd(SEL_READ_MASK, 8'h5a, 1'b1);
    // mask hides index bits from the pixel lookup
    ovl = 4'h0;
    pix = 8'hff;
    repeat (6) @(negedge sys_clk);
    `CHK("masked_color", 24'h000000, color)
    wr(SEL_RESERVED, 8'h77, 1'b1);
    rd(SEL_RESERVED, 8'h00, 1'b1);
    repeat (4) @(negedge sys_clk);
    `CHK("pending_reads", 32'h0, 32'(exp_q.size()))
    end_of_test();
  end
endmodule // palette_dac_host_bus_port_tb
bind palette_dac_host_bus_port palette_port_props chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .host_ctrl(host_ctrl), .host_bus_bits_o(host_bus_bits_o),
  .host_bus_bits_oe(host_bus_bits_oe));
